// ==== serdes_lane_pkg.sv ====
// constants, register map and carrier types for the serial lane control block
package serdes_lane_pkg;

    // ------------------------------------------------------------------
    // geometry and timing
    // ------------------------------------------------------------------
    localparam int          LANES          = 8;
    localparam int          GROUP_LANES    = 4;
    localparam int          CRC_BITS       = 12;
    localparam int          CLK_PERIOD_PS  = 8000;
    localparam int          LINK_INIT_NS   = 1000;
    localparam int          FLUSH_NS       = 2000;
    localparam int          LINK_INIT_CYC  = (LINK_INIT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int          FLUSH_CYC      = (FLUSH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------------
    // register map (byte addresses) and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  ADDR_LINK_CTRL = 8'h00;
    localparam logic [7:0]  ADDR_MODE_CTRL = 8'h04;
    localparam logic [7:0]  ADDR_CHAN_CTRL = 8'h08;
    localparam logic [7:0]  ADDR_STATUS    = 8'h0C;
    localparam int          LC_ENABLE      = 0;
    localparam int          LC_FEC         = 1;
    localparam int          LC_ALT         = 2;
    localparam int          MC_MODE_LSB    = 0;
    localparam int          MC_PD          = 4;
    localparam int          ST_STATE_LSB   = 0;
    localparam int          ST_PD          = 2;
    localparam int          ST_REFUSED     = 3;
    localparam int          ST_VALID       = 4;
    localparam int          ST_DRV_LSB     = 5;
    localparam logic [3:0]  MODE_RESET     = 4'h0;
    localparam logic [1:0]  CHAN_RESET     = 2'h3;

    // lanes each serializer lane mode needs; values are a plain default table
    localparam logic [3:0]  LANES_OF_MODE [0:15] = '{
        4'h8, 4'h4, 4'h2, 4'h4, 4'h8, 4'h4, 4'h2, 4'h1,
        4'h8, 4'h4, 4'h2, 4'h1, 4'h8, 4'h4, 4'h2, 4'h1};

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_INIT = 2'b01,
        LINK_RUN  = 2'b11
    } link_state_type;

    typedef struct packed {
        logic       link_enable;
        logic       fec_select;
        logic       alternate_lane_select;
    } link_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    function automatic logic [3:0] lanes_needed(input logic [3:0] mode);
        return LANES_OF_MODE[mode];
    endfunction : lanes_needed

endpackage : serdes_lane_pkg

// ==== serdes_lane_select_power_down.sv ====
// sync header mode, redundant lane group selection and power-down control for the serial output link
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE_01: sync header offers CRC or FEC
// RULE_02: CRC mode is 12-bit only, no 3-bit
// RULE_03: FEC mode lets receiver detect and correct
// RULE_04: redundancy only for modes needing at most four lanes
// RULE_05: lanes 0-3 default, 4-7 alternate group
// RULE_06: alternate select 0 default, 1 alternate
// RULE_07: only one group carries traffic; modes needing eight lanes drive both groups
// RULE_08: pin or mode field powers whole device down
// RULE_09: power-down pin disables all lane drivers
// RULE_10: link restarts from scratch after power-down
// RULE_11: receiver discards samples until pipelines flush
// RULE_12: configuration survives power-down
// RULE_13: controller recalibrates after large temperature change; this block has no temperature input and never recalibrates
// RULE_14: channel pairs power down individually
// RULE_15: software never disables all pairs this way
// RULE_16: change lane group and mode only while idle
module serdes_lane_select_power_down
    import serdes_lane_pkg::*;
#(
    parameter int LANE_W       = 32,
    parameter int FLUSH_CYCLES = serdes_lane_pkg::FLUSH_CYC,
    parameter int INIT_CYCLES  = serdes_lane_pkg::LINK_INIT_CYC
) (
    input  wire logic                                 clk_sys,
    input  wire logic                                 sys_rst,
    input  wire serdes_lane_pkg::reg_req_type         reg_req,
    output logic [31:0]                               reg_rdata,
    input  wire logic                                 power_down_input,
    input  wire logic [serdes_lane_pkg::LANES*LANE_W-1:0] lane_data_in,
    output logic [serdes_lane_pkg::LANES*LANE_W-1:0]  lane_data_out,
    output logic [serdes_lane_pkg::LANES-1:0]         lane_drv_en,
    output logic [3:0]                                channel_power_en,
    output logic                                      crc12_en,
    output logic                                      fec_en,
    output logic                                      link_running,
    output logic                                      samples_valid
);
    import serdes_lane_pkg::*;

    // counters are 16 bits wide, so longer flush or init times cannot be served
    if (LANE_W < 1 || FLUSH_CYCLES < 1 || INIT_CYCLES < 1 || FLUSH_CYCLES > 65535 || INIT_CYCLES > 65535) begin : g_param_check
        $error("serdes_lane_select_power_down: unsupported parameter value");
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    link_cfg_type   cfg_q;
    logic [3:0]     mode_q;
    logic           mode_pd_q;
    logic [1:0]     chan_pair_q;
    logic           wr_link;
    logic           wr_mode;
    logic           wr_chan;

    assign wr_link = reg_req.wr && (reg_req.addr == ADDR_LINK_CTRL);
    assign wr_mode = reg_req.wr && (reg_req.addr == ADDR_MODE_CTRL);
    assign wr_chan = reg_req.wr && (reg_req.addr == ADDR_CHAN_CTRL);

    // only sys_rst clears these; power-down leaves them untouched
    always_ff @(posedge clk_sys or posedge sys_rst) begin                           // RULE_12
        if (sys_rst) begin
            cfg_q       <= '0;
            mode_q      <= MODE_RESET;
            mode_pd_q   <= 1'b0;
            chan_pair_q <= CHAN_RESET;
        end else begin
            if (wr_link) begin
                cfg_q.link_enable           <= reg_req.wdata[LC_ENABLE];
                cfg_q.fec_select            <= reg_req.wdata[LC_FEC];
                cfg_q.alternate_lane_select <= reg_req.wdata[LC_ALT];
            end
            if (wr_mode) begin
                mode_q    <= reg_req.wdata[MC_MODE_LSB +: 4];
                mode_pd_q <= reg_req.wdata[MC_PD];
            end
            if (wr_chan) begin
                chan_pair_q <= reg_req.wdata[1:0];    // RULE_14
            end
        end
    end

    // ------------------------------------------------------------------
    // power-down and link sequencing
    // ------------------------------------------------------------------
    logic           pd_active;
    logic           pd_q;
    link_state_type state_q;
    link_state_type state_d;
    logic [15:0]    init_cnt_q;
    logic [15:0]    flush_cnt_q;
    logic           alt_eff_q;
    logic           fec_eff_q;
    logic           refused_q;
    logic           alt_allowed;

    assign pd_active   = power_down_input || mode_pd_q;                              // RULE_08
    assign alt_allowed = lanes_needed(mode_q) <= 4'(GROUP_LANES);                    // RULE_04

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pd_q <= 1'b0;
        end else begin
            pd_q <= pd_active;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            LINK_IDLE: begin
                if (cfg_q.link_enable && !pd_active) begin
                    state_d = LINK_INIT;
                end
            end
            LINK_INIT: begin
                if (pd_active || !cfg_q.link_enable) begin
                    state_d = LINK_IDLE;
                end else if (init_cnt_q == 16'(INIT_CYCLES - 1)) begin
                    state_d = LINK_RUN;
                end
            end
            LINK_RUN: begin
                if (pd_active || !cfg_q.link_enable) begin
                    state_d = LINK_IDLE;                                             // RULE_10
                end
            end
            default: begin
                state_d = LINK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_q    <= LINK_IDLE;
            init_cnt_q <= '0;
        end else begin
            state_q    <= state_d;
            init_cnt_q <= (state_q == LINK_INIT && state_d == LINK_INIT) ? init_cnt_q + 16'h0001 : 16'h0000;
        end
    end

    // lane group and header mode are sampled only while idle, so a change mid-run waits for a restart
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            alt_eff_q <= 1'b0;
            fec_eff_q <= 1'b0;
            refused_q <= 1'b0;
        end else if (state_q == LINK_IDLE) begin                                     // RULE_16
            alt_eff_q <= cfg_q.alternate_lane_select && alt_allowed;                 // RULE_04
            fec_eff_q <= cfg_q.fec_select;                                           // RULE_01
            refused_q <= cfg_q.alternate_lane_select && !alt_allowed;
        end
    end

    // pipelines hold stale samples after power-down; valid only once flushed
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flush_cnt_q   <= '0;
            samples_valid <= 1'b0;
        end else if (pd_active) begin
            flush_cnt_q   <= '0;
            samples_valid <= 1'b0;
        end else if (flush_cnt_q != 16'(FLUSH_CYCLES)) begin
            flush_cnt_q   <= flush_cnt_q + 16'h0001;
            samples_valid <= 1'b0;
        end else begin
            samples_valid <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // lane routing and drivers
    // ------------------------------------------------------------------
    logic [LANES-1:0]        act_mask;
    logic [LANES-1:0]        drv_d;
    logic [LANES*LANE_W-1:0] data_d;

    always_comb begin
        act_mask = '0;
        for (int i = 0; i < LANES; i++) begin
            act_mask[i] = 4'(i) < lanes_needed(mode_q);
        end
    end

    generate
        for (genvar g = 0; g < LANES; g++) begin : g_lane
            logic sel;
            if (g < GROUP_LANES) begin : g_low
                // RULE_05 default group feeds from logical lane g
                assign sel = act_mask[g] && !alt_eff_q;                              // RULE_06
                assign data_d[g*LANE_W +: LANE_W] = lane_data_in[g*LANE_W +: LANE_W];
            end else begin : g_high
                // alternate group repeats the low logical lanes; wide modes use it directly
                assign sel = alt_eff_q ? act_mask[g-GROUP_LANES] : act_mask[g];      // RULE_06
                assign data_d[g*LANE_W +: LANE_W] = alt_eff_q ? lane_data_in[(g-GROUP_LANES)*LANE_W +: LANE_W]
                                                              : lane_data_in[g*LANE_W +: LANE_W];
            end
            assign drv_d[g] = sel && !pd_active && (state_q != LINK_IDLE);           // RULE_07 RULE_09
        end
    endgenerate

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lane_drv_en   <= '0;
            lane_data_out <= '0;
        end else begin
            lane_drv_en <= drv_d;                                                    // RULE_09
            for (int i = 0; i < LANES; i++) begin
                lane_data_out[i*LANE_W +: LANE_W] <= drv_d[i] ? data_d[i*LANE_W +: LANE_W] : '0; // RULE_07
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            channel_power_en <= '0;
            crc12_en         <= 1'b0;
            fec_en           <= 1'b0;
            link_running     <= 1'b0;
        end else begin
            channel_power_en <= pd_active ? 4'h0 : {{2{chan_pair_q[1]}}, {2{chan_pair_q[0]}}}; // RULE_08 RULE_14
            crc12_en         <= (state_q != LINK_IDLE) && !fec_eff_q;                // RULE_02
            fec_en           <= (state_q != LINK_IDLE) && fec_eff_q;                 // RULE_03
            link_running     <= state_q == LINK_RUN;
        end
    end

    // ------------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                ADDR_LINK_CTRL: reg_rdata <= {29'h0, cfg_q.alternate_lane_select, cfg_q.fec_select, cfg_q.link_enable};
                ADDR_MODE_CTRL: reg_rdata <= {27'h0, mode_pd_q, mode_q};
                ADDR_CHAN_CTRL: reg_rdata <= {30'h0, chan_pair_q};
                ADDR_STATUS:    reg_rdata <= {19'h0, lane_drv_en, samples_valid, refused_q, pd_q, state_q};
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_pd_seen;
        pd_active;
    endsequence

    sequence s_relink;
        (state_q == LINK_IDLE) ##1 (state_q == LINK_INIT);
    endsequence

    a_pd_drivers_off: assert property (s_pd_seen |=> lane_drv_en == '0) // RULE_09
        else $error("lane drivers on during power-down");
    a_pd_channels_off: assert property (s_pd_seen |=> channel_power_en == 4'h0) // RULE_08
        else $error("channels powered during power-down");
    a_pd_link_drop: assert property (s_pd_seen |=> state_q == LINK_IDLE) // RULE_10
        else $error("link not dropped on power-down");
    a_run_after_init: assert property ($rose(state_q == LINK_RUN) |-> $past(state_q) == LINK_INIT) // RULE_10
        else $error("link ran without initialisation");
    a_relink_path: assert property (s_relink ##1 (state_q == LINK_INIT)[*2] |-> !pd_q) // RULE_10
        else $error("link initialised under power-down");
    a_one_group: assert property (alt_eff_q |-> lane_drv_en[GROUP_LANES-1:0] == '0) // RULE_07
        else $error("default lanes active with alternate selected");
    a_alt_limit: assert property (alt_eff_q |-> lanes_needed(mode_q) <= 4'(GROUP_LANES)) // RULE_04
        else $error("redundancy used by wide lane mode");
    a_alt_route: assert property (alt_eff_q && drv_d[GROUP_LANES] |=>
        lane_data_out[GROUP_LANES*LANE_W +: LANE_W] == $past(lane_data_in[LANE_W-1:0])) // RULE_06
        else $error("alternate lane 4 not carrying logical lane 0");
    a_crc_fec_excl: assert property (!(crc12_en && fec_en)) // RULE_02
        else $error("CRC and FEC both active");
    a_fec_select: assert property ((state_q == LINK_RUN) && fec_eff_q |=> fec_en) // RULE_03
        else $error("FEC not applied while selected");
    a_cfg_retained: assert property (pd_active && !reg_req.wr |=> $stable(cfg_q) && $stable(mode_q)) // RULE_12
        else $error("configuration lost during power-down");
    a_pair_power: assert property (!pd_active && chan_pair_q == 2'b01 |=> channel_power_en == 4'h3) // RULE_14
        else $error("channel pair power does not follow setting");

endmodule : serdes_lane_select_power_down

`default_nettype wire

// ==== lane_receiver.sv ====
// receiving end model: takes lane words only once the link runs and samples are valid
`timescale 1ns/1ps
`default_nettype none

module lane_receiver
    import serdes_lane_pkg::*;
#(
    parameter int LANE_W = 16
) (
    input  wire logic                                     clk_sys,
    input  wire logic                                     sys_rst,
    input  wire logic [serdes_lane_pkg::LANES*LANE_W-1:0] lane_data_out,
    input  wire logic [serdes_lane_pkg::LANES-1:0]        lane_drv_en,
    input  wire logic                                     link_running,
    input  wire logic                                     samples_valid,
    output logic [15:0]                                   words_taken,
    output logic [LANE_W-1:0]                             last_word
);
    import serdes_lane_pkg::*;

    // ----------
    // capture
    // ----------
    // pipeline contents before the flush are meaningless, so they are dropped
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            words_taken <= 16'h0000;
            last_word   <= '0;
        end else if (link_running && samples_valid) begin
            words_taken <= words_taken + 16'h0001;
            last_word   <= lane_drv_en[0] ? lane_data_out[LANE_W-1:0]
                                          : lane_data_out[GROUP_LANES*LANE_W +: LANE_W];
        end
    end
endmodule : lane_receiver

`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the lane select and power-down block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import serdes_lane_pkg::*;
    // ----------
    // signals
    // ----------
    localparam int       LW      = 16;
    logic                clk_sys = 1'b0;
    logic                sys_rst = 1'b1;
    logic                pd_in   = 1'b0;
    reg_req_type         req     = '0;
    logic [LANES*LW-1:0] din;
    logic [LANES*LW-1:0] dout;
    logic [31:0]         rdata;
    logic [31:0]         rdv;
    logic [LANES-1:0]    drv;
    logic [3:0]          chp;
    logic                crc;
    logic                fec;
    logic                run;
    logic                vld;
    logic [15:0]         taken;
    logic [LW-1:0]       rx_word;
    int                  n_fail = 0;
    int                  samples_checked = 0;

    always #4 clk_sys = ~clk_sys;

    serdes_lane_select_power_down #(.LANE_W(LW), .FLUSH_CYCLES(8), .INIT_CYCLES(8)) uut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_req(req), .reg_rdata(rdata),
        .power_down_input(pd_in), .lane_data_in(din), .lane_data_out(dout), .lane_drv_en(drv),
        .channel_power_en(chp), .crc12_en(crc), .fec_en(fec), .link_running(run), .samples_valid(vld));

    lane_receiver #(.LANE_W(LW)) rx (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .lane_data_out(dout), .lane_drv_en(drv),
        .link_running(run), .samples_valid(vld), .words_taken(taken), .last_word(rx_word));

    // ----------
    // helpers
    // ----------
    task automatic report_and_stop();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : check

    function automatic logic [31:0] lane(input int i);
        return {16'h0, dout[i*LW +: LW]};
    endfunction : lane

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a);
        @(posedge clk_sys);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 rdv = rdata;
    endtask : reg_rd

    // bounded wait on link_running, or on samples_valid when on_valid is set
    task automatic wait_for(input bit on_valid);
        int k;
        for (k = 0; k < 400; k++) begin
            cyc(1);
            if (on_valid ? vld === 1'b1 : run === 1'b1) break;
        end
        if (k == 400) begin
            n_fail++;
            report_and_stop();
        end
    endtask : wait_for

    task automatic link_up(input logic [31:0] ctrl);
        reg_wr(ADDR_LINK_CTRL, ctrl);
        wait_for(1'b0);
        cyc(2);
    endtask : link_up

    // lane group and header mode are only changed with the link down
    task automatic link_down();
        reg_wr(ADDR_LINK_CTRL, 32'h0);
        cyc(3);
    endtask : link_down

    // ----------
    // scenarios
    // ----------
    task automatic t_reset();
        cyc(2);
        check("chan_rst", 32'hF, {28'h0, chp});
        check("drv_rst", 32'h0, {24'h0, drv});
        reg_rd(ADDR_CHAN_CTRL);
        check("chan_ctrl", 32'h3, rdv);
        cyc(1);
        check("rdata_gone", 32'h0, rdata);
        reg_wr(8'h10, 32'hFFFFFFFF);
        reg_rd(8'h10);
        check("unmapped", 32'h0, rdv);
        reg_rd(ADDR_MODE_CTRL);
        check("mode_ctrl", 32'h0, rdv);
    endtask : t_reset

    task automatic t_header();
        for (int f = 0; f < 2; f++) begin
            link_up(f ? 32'h3 : 32'h1);
            check("crc12_en", f ? 32'h0 : 32'h1, {31'h0, crc});
            check("fec_en", f ? 32'h1 : 32'h0, {31'h0, fec});
            check("drv_all", 32'hFF, {24'h0, drv});
            check("lane7", 32'hC007, lane(7));
            link_down();
            check("drv_idle", 32'h0, {24'h0, drv});
        end
    endtask : t_header

    task automatic t_lanes();
        link_up(32'h5);
        reg_rd(ADDR_STATUS);
        check("refused", 32'h1, {31'h0, rdv[ST_REFUSED]});
        check("drv_wide", 32'hFF, {24'h0, drv});
        check("lane4_wide", 32'hC004, lane(4));
        link_down();
        reg_wr(ADDR_MODE_CTRL, 32'h1);
        for (int a = 0; a < 2; a++) begin
            link_up(a ? 32'h5 : 32'h1);
            reg_rd(ADDR_STATUS);
            check("refused", 32'h0, {31'h0, rdv[ST_REFUSED]});
            check("drv_group", a ? 32'hF0 : 32'h0F, {24'h0, drv});
            check("lane_sel", 32'hC000, lane(a * 4));
            check("lane_idle", 32'h0, lane(5 - a * 4));
            check("rx_word", 32'hC000, {16'h0, rx_word});
            link_down();
        end
    endtask : t_lanes

    task automatic t_power();
        logic [15:0] n0;
        for (int s = 0; s < 2; s++) begin
            link_up(32'h1);
            @(posedge clk_sys);
            pd_in <= (s == 0);
            if (s == 1) begin
                reg_wr(ADDR_MODE_CTRL, 32'h11);
            end
            cyc(3);
            check("pd_drv", 32'h0, {24'h0, drv});
            check("pd_chan", 32'h0, {28'h0, chp});
            check("pd_run", 32'h0, {31'h0, run});
            check("pd_lane0", 32'h0, lane(0));
            check("pd_valid", 32'h0, {31'h0, vld});
            reg_rd(ADDR_STATUS);
            check("pd_status", 32'h1, {31'h0, rdv[ST_PD]});
            @(posedge clk_sys);
            // temperature is not modelled, so no recalibration is owed after release
            pd_in <= 1'b0;
            if (s == 1) begin
                reg_wr(ADDR_MODE_CTRL, 32'h1);
            end
            cyc(2);
            check("restart", 32'h0, {31'h0, run});
            check("flushing", 32'h0, {31'h0, vld});
            wait_for(1'b0);
            wait_for(1'b1);
            n0 = taken;
            cyc(4);
            check("rx_taking", 32'h4, {16'h0, taken - n0});
            reg_rd(ADDR_LINK_CTRL);
            check("kept_link", 32'h1, rdv);
            reg_rd(ADDR_MODE_CTRL);
            check("kept_mode", 32'h1, rdv);
            link_down();
        end
    endtask : t_power

    // never clears both pairs: whole-device shutdown goes through the pin or mode bit
    task automatic t_pairs();
        for (int p = 1; p < 4; p++) begin
            reg_wr(ADDR_CHAN_CTRL, 32'(p));
            cyc(2);
            check("chan_pwr", (p == 1) ? 32'h3 : (p == 2) ? 32'hC : 32'hF, {28'h0, chp});
            reg_rd(ADDR_CHAN_CTRL);
            check("chan_rb", 32'(p), rdv);
        end
    endtask : t_pairs

    initial begin
        for (int i = 0; i < LANES; i++) begin
            din[i*LW +: LW] = 16'hC000 | 16'(i);
        end
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_reset();
        t_header();
        t_lanes();
        t_power();
        t_pairs();
        report_and_stop();
    end
endmodule : testbench

`default_nettype wire
